// ===== rtl/dio_defines.svh
// register offsets, field positions and reset values of the digital i/o block
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

`define DIO_OFS_DIR_A 12'h000
`define DIO_OFS_DATA_A 12'h004
`define DIO_OFS_DIR_B 12'h008
`define DIO_OFS_DATA_B 12'h00C
`define DIO_OFS_DIR_C 12'h010
`define DIO_OFS_DATA_C 12'h014
`define DIO_OFS_DIR_D 12'h018
`define DIO_OFS_DATA_D 12'h01C
`define DIO_OFS_CMP_A 12'h020
`define DIO_OFS_CMP_B 12'h024
`define DIO_OFS_CMP_C 12'h028
`define DIO_OFS_CMP_D 12'h02C
`define DIO_OFS_CTRL 12'h030
`define DIO_OFS_COS_CLR_A 12'h034
`define DIO_OFS_COS_CLR_B 12'h03C

`define DIO_CTRL_MATCH_EN_LSB 0
`define DIO_CTRL_COS_EN_LSB 4
`define DIO_CTRL_MATCH_FLAG_LSB 8
`define DIO_CTRL_COS_FLAG_LSB 12
`define DIO_CTRL_MATCH_SEL_LSB 16
`define DIO_CTRL_COS_SEL_LSB 20

`define DIO_DIR_RESET 4'hF
`define DIO_DATA_RESET 32'h0000_0000
`define DIO_CMP_RESET 32'h0000_0000

`endif

// ===== rtl/dio_pkg.sv
// types shared by the digital i/o block
package dio_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0] dir_t;
endpackage : dio_pkg

// ===== rtl/dio_port_if.sv
// carries one port's configuration, pins and events between top and port slice
interface dio_port_if;
	logic [3:0] dir;
	logic [31:0] out_val;
	logic [31:0] cmp_val;
	logic [31:0] pin_sync;
	logic [31:0] pin_oe_n;
	logic match;
	logic change;
	modport ctrl (output dir, output out_val, output cmp_val, input pin_sync, input pin_oe_n,
		input match, input change);
	modport slice (input dir, input out_val, input cmp_val, output pin_sync, output pin_oe_n,
		output match, output change);
endinterface : dio_port_if

// ===== rtl/dio_port_slice.sv
// one 32-bit port: pin synchroniser, drivers enable, match and change detection
module dio_port_slice
	import dio_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [31:0] pin_in,
	dio_port_if.slice p
);
	word_t sync1_ff;
	word_t sync2_ff;
	word_t last_ff;
	logic primed_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1_ff <= 32'h0000_0000;
			sync2_ff <= 32'h0000_0000;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			last_ff <= 32'h0000_0000;
			primed_ff <= 1'b0;
		end else begin
			last_ff <= sync2_ff;
			primed_ff <= 1'b1;
		end
	end

	assign p.pin_sync = sync2_ff;
	// enable low drives; a group with direction 1 is input and left undriven
	genvar g;
	for (g = 0; g < 4; g++) begin : g_oe
		assign p.pin_oe_n[g*8 +: 8] = {8{p.dir[g]}};
	end
	assign p.match = (sync2_ff == p.cmp_val);
	assign p.change = primed_ff && (sync2_ff != last_ff);
endmodule : dio_port_slice

// ===== rtl/dio_ports.sv
// Overview of operation
// - direction bits 0..3 steer byte groups
// - direction bit zero makes group output
// - direction read returns programmed group settings
// - all groups input after reset
// - three or four ports by variant
// - input data read returns pin values
// - output write drives pins, reads back
// - compare write stores value, clears match
// - compare read returns stored value
// - control bits 0..3 enable pattern match
// - control bits 4..5 enable change detection
// - bits 8..11 report match flags
// - bits 12..13 report change flags
// - bits 16..19 select match interrupts
// - bits 20..21 select change interrupts
// - clear registers clear change flags
`include "dio_defines.svh"
module dio_ports
	import dio_pkg::*;
#(
	parameter int NUM_PORTS = 4
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [NUM_PORTS*32-1:0] pin_in,
	output logic [NUM_PORTS*32-1:0] pin_out,
	output logic [NUM_PORTS*32-1:0] pin_oe_n,
	output logic irq
);
	// only the three-port and four-port variants exist
	if (NUM_PORTS != 3 && NUM_PORTS != 4) begin : g_bad_ports
		$error("NUM_PORTS must be 3 or 4");
	end

	dir_t dir_ff [4];
	word_t out_ff [4];
	word_t cmp_ff [4];
	logic [3:0] match_en_ff;
	logic [1:0] cos_en_ff;
	logic [3:0] match_sel_ff;
	logic [1:0] cos_sel_ff;
	logic [3:0] match_flag_ff;
	logic [1:0] cos_flag_ff;
	logic [31:0] reg_rdata_ff;
	logic reg_rvalid_ff;
	logic [3:0] match_ev;
	logic [1:0] cos_ev;
	logic [3:0] cmp_wr;
	logic [3:0] port_live;
	word_t pin_sync [4];

	// the fourth port exists only in the larger variant
	assign port_live = (NUM_PORTS == 4) ? 4'hF : 4'h7;

	genvar i;
	for (i = 0; i < 4; i++) begin : g_port
		if (i < NUM_PORTS) begin : g_live
			dio_port_if pif ();
			assign pif.dir = dir_ff[i];
			assign pif.out_val = out_ff[i];
			assign pif.cmp_val = cmp_ff[i];
			dio_port_slice u_slice (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.pin_in(pin_in[i*32 +: 32]),
				.p(pif.slice)
			);
			assign pin_sync[i] = pif.pin_sync;
			assign pin_out[i*32 +: 32] = out_ff[i];
			assign pin_oe_n[i*32 +: 32] = pif.pin_oe_n;
			assign match_ev[i] = match_en_ff[i] && pif.match;
			if (i < 2) begin : g_cos
				assign cos_ev[i] = cos_en_ff[i] && pif.change;
			end
		end else begin : g_dead
			assign pin_sync[i] = 32'h0000_0000;
			assign match_ev[i] = 1'b0;
		end
	end

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			cmp_wr[k] = 1'b0;
		end
		if (reg_wr) begin
			if (reg_addr == `DIO_OFS_CMP_A) begin
				cmp_wr[0] = 1'b1;
			end else if (reg_addr == `DIO_OFS_CMP_B) begin
				cmp_wr[1] = 1'b1;
			end else if (reg_addr == `DIO_OFS_CMP_C) begin
				cmp_wr[2] = 1'b1;
			end else if (reg_addr == `DIO_OFS_CMP_D) begin
				cmp_wr[3] = port_live[3];
			end
		end
	end

	// direction registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int k = 0; k < 4; k++) begin
				dir_ff[k] <= `DIO_DIR_RESET;
			end
		end else if (reg_wr) begin
			if (reg_addr == `DIO_OFS_DIR_A) begin
				dir_ff[0] <= reg_wdata[3:0];
			end else if (reg_addr == `DIO_OFS_DIR_B) begin
				dir_ff[1] <= reg_wdata[3:0];
			end else if (reg_addr == `DIO_OFS_DIR_C) begin
				dir_ff[2] <= reg_wdata[3:0];
			end else if (reg_addr == `DIO_OFS_DIR_D && port_live[3]) begin
				dir_ff[3] <= reg_wdata[3:0];
			end
		end
	end

	// output data registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int k = 0; k < 4; k++) begin
				out_ff[k] <= `DIO_DATA_RESET;
			end
		end else if (reg_wr) begin
			if (reg_addr == `DIO_OFS_DATA_A) begin
				out_ff[0] <= reg_wdata;
			end else if (reg_addr == `DIO_OFS_DATA_B) begin
				out_ff[1] <= reg_wdata;
			end else if (reg_addr == `DIO_OFS_DATA_C) begin
				out_ff[2] <= reg_wdata;
			end else if (reg_addr == `DIO_OFS_DATA_D && port_live[3]) begin
				out_ff[3] <= reg_wdata;
			end
		end
	end

	// compare registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int k = 0; k < 4; k++) begin
				cmp_ff[k] <= `DIO_CMP_RESET;
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (cmp_wr[k]) begin
					cmp_ff[k] <= reg_wdata;
				end
			end
		end
	end

	// control register: enables and interrupt selects
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			match_en_ff <= 4'h0;
			cos_en_ff <= 2'h0;
			match_sel_ff <= 4'h0;
			cos_sel_ff <= 2'h0;
		end else if (reg_wr && reg_addr == `DIO_OFS_CTRL) begin
			match_en_ff <= reg_wdata[`DIO_CTRL_MATCH_EN_LSB +: 4] & port_live;
			cos_en_ff <= reg_wdata[`DIO_CTRL_COS_EN_LSB +: 2];
			match_sel_ff <= reg_wdata[`DIO_CTRL_MATCH_SEL_LSB +: 4] & port_live;
			cos_sel_ff <= reg_wdata[`DIO_CTRL_COS_SEL_LSB +: 2];
		end
	end

	// match flags: a new match wins over the compare-write clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			match_flag_ff <= 4'h0;
		end else begin
			match_flag_ff <= (match_flag_ff & ~cmp_wr) | match_ev;
		end
	end

	// change flags: cleared by their clear registers, a new change wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cos_flag_ff <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (cos_ev[k]) begin
					cos_flag_ff[k] <= 1'b1;
				end else if (reg_wr && reg_wdata[0] &&
					reg_addr == (k == 0 ? `DIO_OFS_COS_CLR_A : `DIO_OFS_COS_CLR_B)) begin
					cos_flag_ff[k] <= 1'b0;
				end
			end
		end
	end

	// interrupt is a level from the selected flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(match_flag_ff & match_sel_ff) | |(cos_flag_ff & cos_sel_ff);
		end
	end

	// read data; input groups show pins, output groups show the written value
	function automatic word_t data_view(input dir_t d, input word_t pins, input word_t outv);
		word_t r;
		r = 32'h0000_0000;
		for (int g = 0; g < 4; g++) begin
			r[g*8 +: 8] = d[g] ? pins[g*8 +: 8] : outv[g*8 +: 8];
		end
		return r;
	endfunction : data_view

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata_ff <= 32'h0000_0000;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd;
			reg_rdata_ff <= 32'h0000_0000;
			if (reg_rd) begin
				if (reg_addr == `DIO_OFS_DIR_A) begin
					reg_rdata_ff <= {28'h0, dir_ff[0]};
				end else if (reg_addr == `DIO_OFS_DIR_B) begin
					reg_rdata_ff <= {28'h0, dir_ff[1]};
				end else if (reg_addr == `DIO_OFS_DIR_C) begin
					reg_rdata_ff <= {28'h0, dir_ff[2]};
				end else if (reg_addr == `DIO_OFS_DIR_D && port_live[3]) begin
					reg_rdata_ff <= {28'h0, dir_ff[3]};
				end else if (reg_addr == `DIO_OFS_DATA_A) begin
					reg_rdata_ff <= data_view(dir_ff[0], pin_sync[0], out_ff[0]);
				end else if (reg_addr == `DIO_OFS_DATA_B) begin
					reg_rdata_ff <= data_view(dir_ff[1], pin_sync[1], out_ff[1]);
				end else if (reg_addr == `DIO_OFS_DATA_C) begin
					reg_rdata_ff <= data_view(dir_ff[2], pin_sync[2], out_ff[2]);
				end else if (reg_addr == `DIO_OFS_DATA_D && port_live[3]) begin
					reg_rdata_ff <= data_view(dir_ff[3], pin_sync[3], out_ff[3]);
				end else if (reg_addr == `DIO_OFS_CMP_A) begin
					reg_rdata_ff <= cmp_ff[0];
				end else if (reg_addr == `DIO_OFS_CMP_B) begin
					reg_rdata_ff <= cmp_ff[1];
				end else if (reg_addr == `DIO_OFS_CMP_C) begin
					reg_rdata_ff <= cmp_ff[2];
				end else if (reg_addr == `DIO_OFS_CMP_D && port_live[3]) begin
					reg_rdata_ff <= cmp_ff[3];
				end else if (reg_addr == `DIO_OFS_CTRL) begin
					// select bits are write-only and the gaps read zero
					reg_rdata_ff <= {18'h0, cos_flag_ff, match_flag_ff, 2'h0, cos_en_ff,
						match_en_ff};
				end
			end
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign reg_rvalid = reg_rvalid_ff;

	// stored direction fields of byte groups feed drivers directly
	dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `DIO_OFS_DIR_A |=> pin_oe_n[7:0] == {8{$past(reg_wdata[0])}})
		else $error("direction write did not steer group enable");
	rst_in_a: assert property (@(posedge ref_clk)
		$fell(sys_rst) |-> &dir_ff[0] && &dir_ff[1] && &dir_ff[2])
		else $error("groups not input after reset");
	cmp_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == `DIO_OFS_CMP_A |=> reg_rdata == $past(cmp_ff[0]) && reg_rvalid)
		else $error("compare read back wrong");
	cmp_clr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cmp_wr[0] && !match_ev[0] |=> !match_flag_ff[0])
		else $error("compare write left match flag set");
	set_win_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		match_ev[0] |=> match_flag_ff[0])
		else $error("match event lost");
	irq_lvl_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		|(match_flag_ff & match_sel_ff) |=> irq)
		else $error("interrupt missing for selected flag");
	cos_clr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `DIO_OFS_COS_CLR_A && reg_wdata[0] && !cos_ev[0]
		|=> !cos_flag_ff[0])
		else $error("change flag not cleared");
	rsv_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rvalid |-> reg_rdata[7:6] == 2'h0 || $past(reg_addr) != `DIO_OFS_CTRL)
		else $error("unused control bits read nonzero");

	// control read, shared by three checks, and selected-flag condition, used by irq_on_a
	sequence ctrl_rd_s;
		reg_rd && reg_addr == `DIO_OFS_CTRL;
	endsequence
	sequence sel_hit_s;
		|(match_flag_ff & match_sel_ff) || |(cos_flag_ff & cos_sel_ff);
	endsequence

	rd_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd |=> reg_rvalid)
		else $error("read not answered");
	rd_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!reg_rd |=> !reg_rvalid && reg_rdata == 32'h0000_0000)
		else $error("read answer without request");
	dir_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == `DIO_OFS_DIR_A |=> reg_rdata == {28'h0, $past(dir_ff[0])})
		else $error("direction read back wrong");
	in_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == `DIO_OFS_DATA_A && dir_ff[0] == 4'hF
		|=> reg_rdata == $past(pin_sync[0]))
		else $error("input data read wrong");
	en_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_rd_s |=> reg_rdata[5:0] == {$past(cos_en_ff), $past(match_en_ff)})
		else $error("enable bits read back wrong");
	flag_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_rd_s |=> reg_rdata[13:8] == {$past(cos_flag_ff), $past(match_flag_ff)})
		else $error("status flags read back wrong");
	sel_hide_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_rd_s |=> reg_rdata[31:14] == 18'h0)
		else $error("write-only or reserved bits read nonzero");
	cos_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cos_ev[1] |=> cos_flag_ff[1])
		else $error("change event lost");
	irq_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sel_hit_s |=> irq)
		else $error("interrupt missing for selected status");
	irq_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(|(match_flag_ff & match_sel_ff)) && !(|(cos_flag_ff & cos_sel_ff)) |=> !irq)
		else $error("interrupt without selected status");
	d_live_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!port_live[3] |-> !match_en_ff[3] && !match_sel_ff[3])
		else $error("absent port has match enabled");
endmodule : dio_ports

// ===== tb/dio_field_model.sv
// field side of the ports: external levels, overridden where the block drives
module dio_field_model #(
	parameter int NUM_PORTS = 4
)
(
	input wire logic [NUM_PORTS*32-1:0] field_val,
	input wire logic [NUM_PORTS*32-1:0] pin_out,
	input wire logic [NUM_PORTS*32-1:0] pin_oe_n,
	output logic [NUM_PORTS*32-1:0] pin_in
);
	// a driven bit shows the block's own level, a released bit the field level
	always_comb begin
		for (int i = 0; i < NUM_PORTS * 32; i++) begin
			pin_in[i] = pin_oe_n[i] ? field_val[i] : pin_out[i];
		end
	end
endmodule : dio_field_model

// ===== tb/dio_ports_match_change_irq_bench.sv
// self-checking bench for the digital i/o ports block
`include "dio_defines.svh"
module dio_ports_match_change_irq_bench import dio_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {string name; word_t exp;} note_t;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	word_t reg_wdata = 32'h0;
	word_t reg_rdata;
	logic reg_rvalid;
	logic [127:0] field = 128'h0;
	logic [127:0] pin_in;
	logic [127:0] pin_out;
	logic [127:0] pin_oe_n;
	logic irq;
	note_t notes[$];
	note_t cur;
	int n_fail = 0;
	int tests_run = 0;
	word_t c[4];
	word_t cv;
	word_t d;
	word_t m;

	dio_ports #(.NUM_PORTS(4)) u_dio_ports (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .irq(irq));
	dio_field_model #(.NUM_PORTS(4)) u_dio_field_model (.field_val(field), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in));

	always #2.5 ref_clk = ~ref_clk;

	task chk(input string n, input word_t e, input word_t g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [11:0] a, input word_t v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [11:0] a, input word_t e, input string n);
		note_t t;
		t.name = n;
		t.exp = e;
		@(posedge ref_clk);
		notes.push_back(t);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task stop_test;
		// a read that never got its answer is a mismatch too
		if (notes.size() != 0) begin
			n_fail++;
			$display("ERROR read answers expected 0 pending seen %0d", notes.size());
		end
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// read results are matched in order against the notes taken at request time
	always @(posedge ref_clk) begin
		if (reg_rvalid === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			chk(cur.name, cur.exp, reg_rdata);
		end
	end

	initial begin
		idle(5000);
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		stop_test();
	end

	initial begin
		void'($urandom(32'h0B50));
		field <= {$urandom, $urandom, $urandom, $urandom};
		idle(5);
		sys_rst <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			rd(`DIO_OFS_DIR_A + 12'(p * 8), 32'h0000_000F, "direction");
			rd(`DIO_OFS_DATA_A + 12'(p * 8), field[p*32 +: 32], "input data");
			chk("pin_oe_n", 32'hFFFF_FFFF, pin_oe_n[p*32 +: 32]);
			chk("pin_out", 32'h0, pin_out[p*32 +: 32]);
		end
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset done");
		for (int p = 0; p < 4; p++) begin
			c[p] = $urandom;
			wr(`DIO_OFS_CMP_A + 12'(p * 4), c[p]);
			rd(`DIO_OFS_CMP_A + 12'(p * 4), c[p], "compare");
		end
		$display("test compare done");
		cv = $urandom;
		field[31:0] <= cv;
		wr(`DIO_OFS_CMP_A, cv);
		// only one interrupt function is selected at a time
		wr(`DIO_OFS_CTRL, 32'h0001_0001);
		idle(5);
		chk("irq", 32'h1, {31'h0, irq});
		rd(`DIO_OFS_CTRL, 32'h0000_0101, "control");
		field[31:0] <= ~cv;
		idle(5);
		rd(`DIO_OFS_CTRL, 32'h0000_0101, "control");
		wr(`DIO_OFS_CMP_A, cv);
		idle(5);
		rd(`DIO_OFS_CTRL, 32'h0000_0001, "control");
		chk("irq", 32'h0, {31'h0, irq});
		wr(`DIO_OFS_CTRL, 32'h0);
		field[31:0] <= cv;
		idle(5);
		rd(`DIO_OFS_CTRL, 32'h0, "control");
		field[31:0] <= ~cv;
		$display("test match done");
		wr(`DIO_OFS_CTRL, 32'h0020_0020);
		idle(5);
		rd(`DIO_OFS_CTRL, 32'h0000_0020, "control");
		field[32] <= ~field[32];
		field[0] <= ~field[0];
		idle(5);
		chk("irq", 32'h1, {31'h0, irq});
		rd(`DIO_OFS_CTRL, 32'h0000_2020, "control");
		wr(`DIO_OFS_COS_CLR_B, 32'h1);
		idle(3);
		rd(`DIO_OFS_CTRL, 32'h0000_0020, "control");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test change done");
		wr(`DIO_OFS_CTRL, 32'hFFC0_FFFF);
		idle(5);
		rd(`DIO_OFS_CTRL, 32'h0000_003F, "control");
		rd(12'h040, 32'h0, "unmapped");
		wr(`DIO_OFS_CTRL, 32'h0);
		$display("test reserved done");
		for (int p = 0; p < 4; p++) begin
			d = $urandom;
			m = 32'hFF << (p * 8);
			// direction is set before the data register is used
			wr(`DIO_OFS_DIR_A + 12'(p * 8), ~(32'h1 << p) & 32'hF);
			wr(`DIO_OFS_DATA_A + 12'(p * 8), d);
			idle(4);
			chk("pin_oe_n", ~m, pin_oe_n[p*32 +: 32]);
			chk("pin_out", d & m, pin_out[p*32 +: 32] & m);
			rd(`DIO_OFS_DATA_A + 12'(p * 8), (d & m) | (field[p*32 +: 32] & ~m), "data");
			rd(`DIO_OFS_DIR_A + 12'(p * 8), ~(32'h1 << p) & 32'hF, "direction");
		end
		$display("test direction done");
		idle(3);
		stop_test();
	end
endmodule : dio_ports_match_change_irq_bench
